// *** i2r_pkg.sv ***
// Shared constants for the receive-side two-wire bus controller.
// Assumes a word-wide memory-mapped slave port and a separate link clock.
package i2r_pkg;

	// Register byte offsets on the memory-mapped port
	localparam logic [4:0] OFF_CTL_SET = 5'h00;
	localparam logic [4:0] OFF_STATUS  = 5'h04;
	localparam logic [4:0] OFF_DATA    = 5'h08;
	localparam logic [4:0] OFF_OWN     = 5'h0C;
	localparam logic [4:0] OFF_CTL_CLR = 5'h18;

	// Control bit positions, shared by the set and clear views; BIT_GC is bit 0 of the own address register
	localparam int BIT_EN  = 6;
	localparam int BIT_STA = 5;
	localparam int BIT_STO = 4;
	localparam int BIT_SI  = 3;
	localparam int BIT_AA  = 2;
	localparam int BIT_GC  = 0;

	// Reset values
	localparam logic [7:0] RST_STATUS = 8'hF8;
	localparam logic [7:0] RST_BYTE   = 8'h00;

	// Status codes
	localparam logic [7:0] ST_START     = 8'h08;
	localparam logic [7:0] ST_RSTART    = 8'h10;
	localparam logic [7:0] ST_MT_ACK    = 8'h18;
	localparam logic [7:0] ST_MT_NACK   = 8'h20;
	localparam logic [7:0] ST_ARB_LOST  = 8'h38;
	localparam logic [7:0] ST_MR_ACK    = 8'h40;
	localparam logic [7:0] ST_MR_NACK   = 8'h48;
	localparam logic [7:0] ST_MR_D_ACK  = 8'h50;
	localparam logic [7:0] ST_MR_D_NACK = 8'h58;
	localparam logic [7:0] ST_SR_OWN    = 8'h60;
	localparam logic [7:0] ST_SR_ARB    = 8'h68;
	localparam logic [7:0] ST_SR_GC     = 8'h70;
	localparam logic [7:0] ST_SR_GC_ARB = 8'h78;
	localparam logic [7:0] ST_SR_D_ACK  = 8'h80;
	localparam logic [7:0] ST_SR_D_NACK = 8'h88;
	localparam logic [7:0] ST_GC_D_ACK  = 8'h90;
	localparam logic [7:0] ST_GC_D_NACK = 8'h98;

	// Serial clock half period, counted on the link clock
	localparam int         SCL_HALF_NS    = 1000;
	localparam int         LINK_PERIOD_NS = 30;
	localparam int         HALF_CYC_I     =
		(SCL_HALF_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
	localparam logic [7:0] HALF_CYC       = 8'(HALF_CYC_I);
	localparam logic [7:0] QTR_CYC        = 8'(HALF_CYC_I / 2);

	// Bit counting and addresses
	localparam logic [3:0] BITS_DATA  = 4'h8;
	localparam logic [3:0] BITS_ACK   = 4'h9;
	localparam logic [7:0] GCALL_BYTE = 8'h00;

	// Phases of a master bit or bus condition
	localparam logic [1:0] PH_LOW  = 2'h0;
	localparam logic [1:0] PH_HIGH = 2'h1;
	localparam logic [1:0] PH_LAST = 2'h2;

	typedef enum logic [2:0] {
		S_IDLE,
		S_COND,
		S_MBIT,
		S_SBIT,
		S_HOLD
	} i2r_state_t;

endpackage

// *** i2r_rx_core.sv ***
// Receive-side two-wire bus controller: master receiver and slave
// receiver addressing, registers on a memory-mapped slave port.
// Assumes open-drain pins resolved outside; link logic on link_clk.
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE1 - Software loads address plus read, clears flag
// RULE2 - Flag again after address acknowledge sampled
// RULE3 - Repeated start resends loaded address byte
// RULE4 - Arbitration lost: release, or restart when free
// RULE5 - After read address ack, receive byte
// RULE6 - Address nack: restart or stop, clear stop
// RULE7 - Byte acked: receive next, ack per bit
// RULE8 - Byte nacked: restart or stop as asked
// RULE9 - Answer own address in upper seven bits
// RULE10 - Broadcast call answered only when enabled
// RULE11 - Software enables block and acknowledge first
// RULE12 - Rate settings unused while acting as slave
// RULE13 - Slave receiver only on own write address
// RULE14 - Lost arbitration then addressed: slave receiver
// RULE15 - Acknowledge cleared: nack after next byte
// RULE16 - Acknowledge clear ignores addresses, still monitors
// RULE17 - After slave address ack, receive byte
// RULE18 - Begin request waits free bus, sends start
// RULE19 - Serial clock held low while flag set; not held after ST_ARB_LOST
module i2r_rx_core
	import i2r_pkg::*;
(
	// System clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// Memory-mapped slave port
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Link clock
	input  wire logic        link_clk,
	// Serial clock pin
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	// Serial data pin
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe
);

	// ---------------- System domain ----------------
	logic        ack_ff,    nxt_ack;
	logic [31:0] rdata_ff,  nxt_rdata;
	logic        en_ff,     nxt_en;
	logic        sta_ff,    nxt_sta;
	logic        sto_ff,    nxt_sto;
	logic        si_ff,     nxt_si;
	logic        aa_ff,     nxt_aa;
	logic [7:0]  own_ff,    nxt_own;
	logic [7:0]  dat_ff,    nxt_dat;
	logic [7:0]  stat_ff,   nxt_stat;
	logic        go_ff,     nxt_go;
	logic [1:0]  x1_ff;
	logic [1:0]  x2_ff;
	logic [1:0]  x3_ff;
	logic [7:0]  ctl_rd;
	logic        wr_ok;
	logic        wr_set;
	logic        wr_clr;
	logic        evt_edge;
	logic        stod_edge;

	// Link domain state visible to the system side
	logic        evt_ff,    nxt_evt;
	logic        stod_ff,   nxt_stod;
	logic [7:0]  lstat_ff,  nxt_lstat;
	logic [7:0]  rxd_ff,    nxt_rxd;

	// Bus handshake and write decode
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
	assign avs_readdata    = rdata_ff;
	assign wr_ok  = avs_write & ack_ff & avs_byteenable[0];
	assign wr_set = wr_ok & (avs_address == OFF_CTL_SET);
	assign wr_clr = wr_ok & (avs_address == OFF_CTL_CLR);
	assign evt_edge  = x2_ff[1] ^ x3_ff[1];
	assign stod_edge = x2_ff[0] ^ x3_ff[0];

	// Control view as read back
	always_comb begin
		ctl_rd          = '0;
		ctl_rd[BIT_EN]  = en_ff;
		ctl_rd[BIT_STA] = sta_ff;
		ctl_rd[BIT_STO] = sto_ff;
		ctl_rd[BIT_SI]  = si_ff;
		ctl_rd[BIT_AA]  = aa_ff;
	end

	// Register file next state
	always_comb begin
		nxt_ack   = (avs_read | avs_write) & ~ack_ff;
		nxt_rdata = rdata_ff;
		if (avs_read & ~ack_ff) begin
			if (avs_address == OFF_CTL_SET)
				nxt_rdata = 32'(ctl_rd);
			else if (avs_address == OFF_STATUS)
				nxt_rdata = 32'(stat_ff);
			else if (avs_address == OFF_DATA)
				nxt_rdata = 32'(dat_ff);
			else if (avs_address == OFF_OWN)
				nxt_rdata = 32'(own_ff);
			else
				nxt_rdata = '0;
		end
		nxt_en  = (en_ff | (wr_set & avs_writedata[BIT_EN]))
			& ~(wr_clr & avs_writedata[BIT_EN]);
		nxt_sta = (sta_ff | (wr_set & avs_writedata[BIT_STA]))
			& ~(wr_clr & avs_writedata[BIT_STA]);
		nxt_aa  = (aa_ff | (wr_set & avs_writedata[BIT_AA]))
			& ~(wr_clr & avs_writedata[BIT_AA]);
		// Stop auto-clear after the stop is sent; a set wins [RULE6] [RULE8]
		nxt_sto = (wr_set & avs_writedata[BIT_STO]) | (sto_ff & ~stod_edge);
		// Flag set by the link wins over a software clear [RULE2]
		nxt_si  = evt_edge | (si_ff & ~(wr_clr & avs_writedata[BIT_SI]));
		// Clearing a set flag releases the link [RULE1]
		nxt_go  = go_ff ^ (wr_clr & avs_writedata[BIT_SI] & si_ff
			& ~evt_edge);
		nxt_own = own_ff;
		if (wr_ok & (avs_address == OFF_OWN))
			nxt_own = avs_writedata[7:0];
		nxt_dat  = dat_ff;
		nxt_stat = stat_ff;
		if (evt_edge) begin
			nxt_dat  = rxd_ff;
			nxt_stat = lstat_ff;
		end else if (wr_ok & (avs_address == OFF_DATA)) begin
			nxt_dat = avs_writedata[7:0];
		end
	end

	// Register file flops and link event synchroniser
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ack_ff   <= 1'b0;
			rdata_ff <= '0;
			en_ff    <= 1'b0;
			sta_ff   <= 1'b0;
			sto_ff   <= 1'b0;
			si_ff    <= 1'b0;
			aa_ff    <= 1'b0;
			own_ff   <= RST_BYTE;
			dat_ff   <= RST_BYTE;
			stat_ff  <= RST_STATUS;
			go_ff    <= 1'b0;
			x1_ff    <= '0;
			x2_ff    <= '0;
			x3_ff    <= '0;
		end else begin
			ack_ff   <= nxt_ack;
			rdata_ff <= nxt_rdata;
			en_ff    <= nxt_en;
			sta_ff   <= nxt_sta;
			sto_ff   <= nxt_sto;
			si_ff    <= nxt_si;
			aa_ff    <= nxt_aa;
			own_ff   <= nxt_own;
			dat_ff   <= nxt_dat;
			stat_ff  <= nxt_stat;
			go_ff    <= nxt_go;
			x1_ff    <= {evt_ff, stod_ff};
			x2_ff    <= x1_ff;
			x3_ff    <= x2_ff;
		end
	end

	// ---------------- Link domain ----------------
	logic        lrst1_ff;
	logic        lrst_ff;
	logic [22:0] s1_ff;
	logic [22:0] s2_ff;
	logic        gop_ff;
	logic        sclp_ff;
	logic        sdap_ff;
	logic        go_s, scl_s, sda_s, en_s, sta_s, sto_s, aa_s;
	logic [7:0]  own_s;
	logic [7:0]  tx_s;
	i2r_state_t  st_ff,     nxt_st;
	logic [7:0]  cnt_ff,    nxt_cnt;
	logic [1:0]  ph_ff,     nxt_ph;
	logic [3:0]  bit_ff,    nxt_bit;
	logic [7:0]  shr_ff,    nxt_shr;
	logic        scloe_ff,  nxt_scloe;
	logic        sdaoe_ff,  nxt_sdaoe;
	logic        busy_ff,   nxt_busy;
	logic        adr_ff,    nxt_adr;
	logic        rw_ff,     nxt_rw;
	logic        arb_ff,    nxt_arb;
	logic        gc_ff,     nxt_gc;
	logic        acked_ff,  nxt_acked;
	logic        stop_ff,   nxt_stop;
	logic        rs_ff,     nxt_rs;
	logic        go_edge, rise, fall, start_det, stop_det;
	logic        stall, step, gcall_hit, own_hit, addr_hit;

	// Reset release aligned to the link clock
	always_ff @(posedge link_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lrst1_ff <= 1'b1;
			lrst_ff  <= 1'b1;
		end else begin
			lrst1_ff <= 1'b0;
			lrst_ff  <= lrst1_ff;
		end
	end

	// Two-stage synchroniser for pins, controls and release toggle
	always_ff @(posedge link_clk or posedge lrst_ff) begin
		if (lrst_ff) begin
			s1_ff   <= '0;
			s2_ff   <= '0;
			gop_ff  <= 1'b0;
			sclp_ff <= 1'b1;
			sdap_ff <= 1'b1;
		end else begin
			s1_ff   <= {go_ff, scl_in, sda_in, en_ff, sta_ff, sto_ff,
				aa_ff, own_ff, dat_ff};
			s2_ff   <= s1_ff;
			gop_ff  <= go_s;
			sclp_ff <= scl_s;
			sdap_ff <= sda_s;
		end
	end

	assign {go_s, scl_s, sda_s, en_s, sta_s, sto_s, aa_s, own_s, tx_s}
		= s2_ff;

	// Bus events and address recognition
	assign go_edge   = go_s ^ gop_ff;
	assign rise      = scl_s & ~sclp_ff;
	assign fall      = ~scl_s & sclp_ff;
	assign start_det = scl_s & sclp_ff & sdap_ff & ~sda_s;
	assign stop_det  = scl_s & sclp_ff & ~sdap_ff & sda_s;
	assign stall     = (ph_ff == PH_HIGH) & ~scl_s;
	assign step      = ~stall & (cnt_ff == HALF_CYC);
	assign gcall_hit = (shr_ff == GCALL_BYTE) & own_s[BIT_GC]; // [RULE10]
	assign own_hit   = (shr_ff[7:1] == own_s[7:1]) & ~shr_ff[0]; // [RULE9] [RULE13]
	assign addr_hit  = aa_s & (own_hit | gcall_hit); // [RULE16]

	// Pins are open drain: only ever pulled low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe  = scloe_ff;
	assign sda_oe  = sdaoe_ff;

	// Bus engine next state
	always_comb begin
		nxt_st    = st_ff;
		nxt_cnt   = cnt_ff;
		nxt_ph    = ph_ff;
		nxt_bit   = bit_ff;
		nxt_shr   = shr_ff;
		nxt_scloe = scloe_ff;
		nxt_sdaoe = sdaoe_ff;
		nxt_lstat = lstat_ff;
		nxt_rxd   = rxd_ff;
		nxt_evt   = evt_ff;
		nxt_stod  = stod_ff;
		nxt_adr   = adr_ff;
		nxt_rw    = rw_ff;
		nxt_arb   = arb_ff;
		nxt_gc    = gc_ff;
		nxt_acked = acked_ff;
		nxt_stop  = stop_ff;
		nxt_rs    = rs_ff;
		nxt_busy  = start_det | (busy_ff & ~stop_det);
		if ((st_ff == S_COND) | (st_ff == S_MBIT)) begin
			if (!stall)
				nxt_cnt = step ? '0 : cnt_ff + 8'h01;
		end
		if (!en_s) begin
			nxt_st    = S_IDLE;
			nxt_scloe = 1'b0;
			nxt_sdaoe = 1'b0;
		end else begin
			case (st_ff)
			S_IDLE: begin
				nxt_scloe = 1'b0;
				nxt_sdaoe = 1'b0;
				if (start_det) begin
					nxt_st  = S_SBIT;
					nxt_bit = '0;
					nxt_adr = 1'b1;
					nxt_arb = 1'b0;
				end else if (sta_s & ~busy_ff & scl_s & sda_s) begin
					// Start only once the bus is free [RULE4] [RULE18]
					nxt_st   = S_COND;
					nxt_stop = 1'b0;
					nxt_rs   = 1'b0;
					nxt_ph   = PH_HIGH;
					nxt_cnt  = '0;
					nxt_arb  = 1'b0;
				end
			end
			S_COND: begin
				if (step) begin
					nxt_ph = ph_ff + 2'h1;
					if (ph_ff == PH_LOW) begin
						nxt_scloe = 1'b0;
					end else if (ph_ff == PH_HIGH) begin
						nxt_sdaoe = ~stop_ff;
					end else if (stop_ff) begin
						// Stop sent: end request clears itself [RULE6] [RULE8]
						nxt_stod = ~stod_ff;
						nxt_st   = S_IDLE;
					end else begin
						nxt_scloe = 1'b1;
						nxt_lstat = rs_ff ? ST_RSTART : ST_START; // [RULE18]
						nxt_evt   = ~evt_ff;
						nxt_st    = S_HOLD;
					end
				end
			end
			S_MBIT: begin
				// Data changes at mid low phase; ack follows current bit
				if ((ph_ff == PH_LOW) & (cnt_ff == QTR_CYC)) begin
					if (bit_ff < BITS_DATA)
						nxt_sdaoe = adr_ff & ~shr_ff[7];
					else
						nxt_sdaoe = ~adr_ff & aa_s; // [RULE5] [RULE7] [RULE15]
				end
				if (step & (ph_ff == PH_LOW)) begin
					nxt_scloe = 1'b0;
					nxt_ph    = PH_HIGH;
				end else if (step) begin
					nxt_ph = PH_LOW;
					if (bit_ff < BITS_DATA) begin
						nxt_shr = {shr_ff[6:0], sda_s};
						nxt_bit = bit_ff + 4'h1;
						if (adr_ff & shr_ff[7] & ~sda_s) begin
							// Lost while addressing: listen as slave [RULE14]
							nxt_arb   = 1'b1;
							nxt_sdaoe = 1'b0;
							nxt_st    = S_SBIT;
						end else begin
							nxt_scloe = 1'b1;
						end
					end else if (~adr_ff & ~sdaoe_ff & ~sda_s) begin
						// Lost in our not-acknowledge bit [RULE4]
						nxt_lstat = ST_ARB_LOST;
						nxt_evt   = ~evt_ff;
						nxt_st    = S_HOLD;
					end else begin
						nxt_scloe = 1'b1; // [RULE19]
						nxt_evt   = ~evt_ff;
						nxt_st    = S_HOLD;
						if (adr_ff & rw_ff)
							nxt_lstat = sda_s ? ST_MR_NACK : ST_MR_ACK; // [RULE2]
						else if (adr_ff)
							nxt_lstat = sda_s ? ST_MT_NACK : ST_MT_ACK;
						else begin
							nxt_lstat = sda_s ? ST_MR_D_NACK : ST_MR_D_ACK;
							nxt_rxd   = shr_ff;
						end
					end
				end
			end
			S_SBIT: begin
				// Follows the remote clock; the rate count is unused [RULE12]
				nxt_scloe = 1'b0;
				if (stop_det) begin
					nxt_sdaoe = 1'b0;
					nxt_st    = S_IDLE;
				end else if (start_det) begin
					nxt_sdaoe = 1'b0;
					nxt_bit   = '0;
					nxt_adr   = 1'b1;
					nxt_arb   = 1'b0;
				end else if (rise & (bit_ff < BITS_DATA)) begin
					nxt_shr = {shr_ff[6:0], sda_s};
					nxt_bit = bit_ff + 4'h1;
				end else if (rise & (bit_ff == BITS_DATA)) begin
					nxt_bit = BITS_ACK;
				end else if (fall & (bit_ff == BITS_DATA)) begin
					if (~adr_ff) begin
						nxt_sdaoe = aa_s; // [RULE15] [RULE17]
						nxt_acked = aa_s;
					end else if (addr_hit) begin
						nxt_sdaoe = 1'b1; // [RULE13] [RULE16]
						nxt_gc    = gcall_hit;
					end else if (arb_ff) begin
						nxt_lstat = ST_ARB_LOST; // [RULE4]
						nxt_evt   = ~evt_ff;
						nxt_st    = S_HOLD;
					end else begin
						nxt_st = S_IDLE;
					end
				end else if (fall & (bit_ff == BITS_ACK)) begin
					nxt_sdaoe = 1'b0;
					nxt_scloe = 1'b1; // [RULE19]
					nxt_evt   = ~evt_ff;
					nxt_st    = S_HOLD;
					if (adr_ff & gc_ff)
						nxt_lstat = arb_ff ? ST_SR_GC_ARB : ST_SR_GC; // [RULE14]
					else if (adr_ff)
						nxt_lstat = arb_ff ? ST_SR_ARB : ST_SR_OWN; // [RULE14]
					else begin
						nxt_rxd = shr_ff;
						if (gc_ff)
							nxt_lstat = acked_ff ? ST_GC_D_ACK : ST_GC_D_NACK;
						else
							nxt_lstat = acked_ff ? ST_SR_D_ACK : ST_SR_D_NACK;
					end
				end
			end
			S_HOLD: begin
				// Clock stays low until software releases the flag, except after ST_ARB_LOST [RULE19]
				nxt_sdaoe = 1'b0;
				if (go_edge) begin
					nxt_bit = '0;
					nxt_ph  = PH_LOW;
					nxt_cnt = '0;
					case (lstat_ff)
					ST_START, ST_RSTART: begin
						nxt_shr = tx_s; // [RULE1] [RULE3]
						nxt_rw  = tx_s[0];
						nxt_adr = 1'b1;
						nxt_st  = S_MBIT;
					end
					ST_MR_ACK, ST_MR_D_ACK: begin
						nxt_adr = 1'b0; // [RULE5] [RULE7]
						nxt_st  = S_MBIT;
					end
					ST_MR_NACK, ST_MR_D_NACK, ST_MT_ACK, ST_MT_NACK: begin
						// Stop (then start) or repeated start [RULE6] [RULE8]
						nxt_st    = S_COND;
						nxt_stop  = sto_s | ~sta_s;
						nxt_rs    = ~sto_s & sta_s;
						nxt_sdaoe = sto_s | ~sta_s;
					end
					ST_SR_OWN, ST_SR_ARB, ST_SR_GC, ST_SR_GC_ARB,
					ST_SR_D_ACK, ST_GC_D_ACK: begin
						nxt_adr   = 1'b0; // [RULE17]
						nxt_scloe = 1'b0;
						nxt_st    = S_SBIT;
					end
					default: begin
						// Lost and not addressed, or byte refused as slave; idle restarts if begin set [RULE4]
						nxt_scloe = 1'b0;
						nxt_st    = S_IDLE;
					end
					endcase
				end
			end
			default: nxt_st = S_IDLE;
			endcase
		end
	end

	// Bus engine flops
	always_ff @(posedge link_clk or posedge lrst_ff) begin
		if (lrst_ff) begin
			st_ff    <= S_IDLE;
			cnt_ff   <= '0;
			ph_ff    <= PH_LOW;
			bit_ff   <= '0;
			shr_ff   <= RST_BYTE;
			scloe_ff <= 1'b0;
			sdaoe_ff <= 1'b0;
			lstat_ff <= RST_STATUS;
			rxd_ff   <= RST_BYTE;
			evt_ff   <= 1'b0;
			stod_ff  <= 1'b0;
			busy_ff  <= 1'b0;
			adr_ff   <= 1'b0;
			rw_ff    <= 1'b0;
			arb_ff   <= 1'b0;
			gc_ff    <= 1'b0;
			acked_ff <= 1'b0;
			stop_ff  <= 1'b0;
			rs_ff    <= 1'b0;
		end else begin
			st_ff    <= nxt_st;
			cnt_ff   <= nxt_cnt;
			ph_ff    <= nxt_ph;
			bit_ff   <= nxt_bit;
			shr_ff   <= nxt_shr;
			scloe_ff <= nxt_scloe;
			sdaoe_ff <= nxt_sdaoe;
			lstat_ff <= nxt_lstat;
			rxd_ff   <= nxt_rxd;
			evt_ff   <= nxt_evt;
			stod_ff  <= nxt_stod;
			busy_ff  <= nxt_busy;
			adr_ff   <= nxt_adr;
			rw_ff    <= nxt_rw;
			arb_ff   <= nxt_arb;
			gc_ff    <= nxt_gc;
			acked_ff <= nxt_acked;
			stop_ff  <= nxt_stop;
			rs_ff    <= nxt_rs;
		end
	end

endmodule

`default_nettype wire

// *** i2r_rx_checker.sv ***
// Port checker for the receive-side two-wire bus controller.
// Assumes it is bound onto i2r_rx_core; pins sampled on link_clk.
`timescale 1ns/1ps
`default_nettype none
module i2r_rx_checker (
	// Clocks and reset
	input wire logic        clock,
	input wire logic        sys_rst,
	input wire logic        link_clk,
	// Register port
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Pins
	input wire logic        scl_out,
	input wire logic        scl_oe,
	input wire logic        sda_out,
	input wire logic        sda_oe
);
	// Register port handshake
	a_wait_idle: assert property (@(posedge clock) disable iff (sys_rst)
		!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest raised with no request");
	a_wait_one: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	a_rd_upper: assert property (@(posedge clock) disable iff (sys_rst)
		avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_rd_stable: assert property (@(posedge clock) disable iff (sys_rst)
		!avs_read |=> $stable(avs_readdata))
		else $error("read data changed without a read");
	// Pins stay open drain and quiet out of reset
	a_pins_od: assert property (@(posedge link_clk) disable iff (sys_rst)
		!scl_out && !sda_out)
		else $error("pin driven high");
	a_rst_quiet: assert property (@(posedge link_clk) disable iff (sys_rst)
		$fell(sys_rst) |-> !scl_oe && !sda_oe)
		else $error("pins pulled low right after reset");
	a_scl_hold: assert property (@(posedge link_clk) disable iff (sys_rst)
		$rose(scl_oe) |-> scl_oe [*4])
		else $error("clock low pulse too short");
	a_sda_hold: assert property (@(posedge link_clk) disable iff (sys_rst)
		$rose(sda_oe) |-> sda_oe [*2])
		else $error("data low pulse too short");
endmodule
`default_nettype wire

// *** i2r_bus_model.sv ***
// Far-side bus model: a slave transmitter and a master transmitter.
// Assumes pull-ups on both wires and levels resolved by the bench.
`timescale 1ns/1ps
`default_nettype none
module i2r_bus_model #(
	parameter logic [6:0] SLV_ADDR = 7'h35,
	parameter int         HALF_NS  = 200
) (
	// Resolved wire levels
	input  wire logic scl_w,
	input  wire logic sda_w,
	// Pull-down enables of this model
	output logic      m_scl_oe,
	output logic      m_sda_oe
);
	logic [7:0] tx_byte  = 8'h00;  // Byte served as slave
	logic       dev_nack = 1'b0;   // Level returned by device, 1 = NACK
	int         stops    = 0;      // Stop conditions seen
	logic [7:0] sh;
	int         j;

	initial begin
		m_scl_oe = 1'b0;
		m_sda_oe = 1'b0;
	end

	// Count stop conditions on the wire
	always @(posedge sda_w) begin
		if (scl_w === 1'b1)
			stops++;
	end

	// Slave transmitter answering its address with read bit
	always @(negedge sda_w) begin
		if (scl_w === 1'b1) begin
			for (j = 0; j < 8; j++) begin
				@(posedge scl_w);
				sh = {sh[6:0], sda_w};
			end
			if (sh == {SLV_ADDR, 1'b1}) begin
				@(negedge scl_w);
				#40 m_sda_oe = 1'b1;
				for (j = 7; j >= 0; j--) begin
					@(negedge scl_w);
					#40 m_sda_oe = !tx_byte[j];
				end
				@(negedge scl_w);
				#40 m_sda_oe = 1'b0;
				@(posedge scl_w);
				dev_nack = sda_w;
			end
		end
	end

	// Release clock, wait out any stretch, hold high
	task automatic scl_up();
		m_scl_oe = 1'b0;
		for (int k = 0; k < 5000 && scl_w !== 1'b1; k++)
			#10;
		#HALF_NS;
	endtask

	task automatic m_start();
		m_sda_oe = 1'b1;
		#HALF_NS;
		m_scl_oe = 1'b1;
	endtask

	// Send a byte MSB first, return the ack level
	task automatic m_byte(input logic [7:0] b, output logic nack);
		for (int k = 7; k >= 0; k--) begin
			#(HALF_NS/2) m_sda_oe = !b[k];
			#(HALF_NS/2);
			scl_up();
			m_scl_oe = 1'b1;
		end
		#(HALF_NS/2) m_sda_oe = 1'b0;
		#(HALF_NS/2);
		scl_up();
		nack = sda_w;
		m_scl_oe = 1'b1;
	endtask

	task automatic m_stop();
		#(HALF_NS/2) m_sda_oe = 1'b1;
		#(HALF_NS/2);
		scl_up();
		m_sda_oe = 1'b0;
		#HALF_NS;
	endtask
endmodule
`default_nettype wire

// *** tb_i2c_master_rx_slave_rx.sv ***
// Self-checking bench: register port, slave addressing, master read.
// Assumes the bus model on the far side and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_master_rx_slave_rx
	import i2r_pkg::*;
;
	logic        clock = 1'b0;
	logic        link_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        scl_out, scl_oe, sda_out, sda_oe, m_scl_oe, m_sda_oe;
	wire logic   scl_w = !(scl_oe || m_scl_oe);
	wire logic   sda_w = !(sda_oe || m_sda_oe);
	int          num_errors = 0;
	int          cmp_count = 0;
	int          s0;
	logic [7:0]  rd, b, ab;
	logic [6:0]  oa;
	logic        nk;
	logic [4:0]  ra [5] = '{OFF_CTL_SET, OFF_STATUS, OFF_DATA, OFF_OWN, 5'h10};
	logic [7:0]  rv [5] = '{8'h00, RST_STATUS, RST_BYTE, 8'h00, 8'h00};
	logic [9:0]  ic [4];

	always #2 clock = ~clock;
	always #15 link_clk = ~link_clk;

	i2r_rx_core i_i2r_rx_core (.clock, .sys_rst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .link_clk, .scl_in(scl_w), .scl_out, .scl_oe,
		.sda_in(sda_w), .sda_out, .sda_oe);
	i2r_bus_model i_i2r_bus_model (.scl_w, .sda_w, .m_scl_oe, .m_sda_oe);

	task automatic stop_test();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One register access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [7:0] d, input logic [3:0] be, output logic [7:0] q);
		int n;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= be;
		avs_read <= !w;
		avs_write <= w;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) begin
			num_errors++;
			stop_test();
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, {3'($urandom), 1'b1}, q);
	endtask

	// Read until the masked value appears, bounded
	task automatic poll(input logic [4:0] a, input logic [7:0] m, e);
		for (int k = 0; k < 12000; k++) begin
			bus(1'b0, a, 8'h00, 4'hF, rd);
			if ((rd & m) === e)
				break;
		end
		chk("poll", e, rd & m);
		if ((rd & m) !== e)
			stop_test();
	endtask

	initial begin
		void'($urandom(32'h4960));
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		// Reset values, unmapped and byte-disabled writes ignored
		wr(5'h10, 8'hFF);
		bus(1'b1, OFF_OWN, 8'hFF, 4'hE, rd);
		for (int k = 0; k < 5; k++) begin
			bus(1'b0, ra[k], 8'h00, 4'hF, rd);
			chk("reset", rv[k], rd);
		end
		oa = 7'($urandom_range(127, 64));
		wr(OFF_CTL_SET, 8'h44);
		bus(1'b0, OFF_CTL_SET, 8'h00, 4'hF, rd);
		chk("ctl", 8'h44, rd);
		// Addresses that must go unanswered: {byte, gc, aa}
		ic = '{{oa, 3'b111}, {8'h00, 2'b01}, {oa, 3'b010}, {oa ^ 7'h01, 3'b011}};
		for (int k = 0; k < 4; k++) begin
			wr(OFF_OWN, {oa, ic[k][1]});
			wr(ic[k][0] ? OFF_CTL_SET : OFF_CTL_CLR, 8'h04);
			i_i2r_bus_model.m_start();
			i_i2r_bus_model.m_byte(ic[k][9:2], nk);
			chk("ignored", 8'h01, {7'h0, nk});
			i_i2r_bus_model.m_stop();
		end
		// Own address then broadcast call: one byte acked, one refused
		wr(OFF_OWN, {oa, 1'b1});
		for (int k = 0; k < 2; k++) begin
			wr(OFF_CTL_SET, 8'h04);
			ab = k ? GCALL_BYTE : {oa, 1'b0};
			i_i2r_bus_model.m_start();
			i_i2r_bus_model.m_byte(ab, nk);
			chk("addr ack", 8'h00, {7'h0, nk});
			poll(OFF_STATUS, 8'hFF, k ? ST_SR_GC : ST_SR_OWN);
			b = 8'($urandom);
			wr(OFF_CTL_CLR, 8'h08);
			i_i2r_bus_model.m_byte(b, nk);
			chk("data ack", 8'h00, {7'h0, nk});
			poll(OFF_STATUS, 8'hFF, k ? ST_GC_D_ACK : ST_SR_D_ACK);
			bus(1'b0, OFF_DATA, 8'h00, 4'hF, rd);
			chk("data", b, rd);
			wr(OFF_CTL_CLR, 8'h0C);
			i_i2r_bus_model.m_byte(~b, nk);
			chk("data nack", 8'h01, {7'h0, nk});
			poll(OFF_STATUS, 8'hFF, k ? ST_GC_D_NACK : ST_SR_D_NACK);
			wr(OFF_CTL_CLR, 8'h08);
			i_i2r_bus_model.m_stop();
		end
		// Master read: start, address, one byte refused, stop then start
		s0 = i_i2r_bus_model.stops;
		i_i2r_bus_model.tx_byte = 8'($urandom);
		wr(OFF_CTL_SET, 8'h20);
		poll(OFF_STATUS, 8'hFF, ST_START);
		wr(OFF_DATA, {i_i2r_bus_model.SLV_ADDR ^ 7'h01, 1'b1});
		wr(OFF_CTL_CLR, 8'h28);
		poll(OFF_STATUS, 8'hFF, ST_MR_NACK);
		// Begin request alone after a refused address: repeated start
		wr(OFF_CTL_SET, 8'h20);
		wr(OFF_CTL_CLR, 8'h08);
		poll(OFF_STATUS, 8'hFF, ST_RSTART);
		wr(OFF_DATA, {i_i2r_bus_model.SLV_ADDR, 1'b1});
		wr(OFF_CTL_CLR, 8'h28);
		poll(OFF_STATUS, 8'hFF, ST_MR_ACK);
		wr(OFF_CTL_CLR, 8'h08);
		poll(OFF_STATUS, 8'hFF, ST_MR_D_NACK);
		bus(1'b0, OFF_DATA, 8'h00, 4'hF, rd);
		chk("rx byte", i_i2r_bus_model.tx_byte, rd);
		chk("dev nack", 8'h01, {7'h0, i_i2r_bus_model.dev_nack});
		wr(OFF_CTL_SET, 8'h30);
		wr(OFF_CTL_CLR, 8'h08);
		poll(OFF_STATUS, 8'hFF, ST_START);
		poll(OFF_CTL_SET, 8'h10, 8'h00);
		wr(OFF_DATA, {i_i2r_bus_model.SLV_ADDR ^ 7'h01, 1'b1});
		wr(OFF_CTL_CLR, 8'h28);
		poll(OFF_STATUS, 8'hFF, ST_MR_NACK);
		wr(OFF_CTL_SET, 8'h10);
		wr(OFF_CTL_CLR, 8'h08);
		poll(OFF_CTL_SET, 8'h10, 8'h00);
		repeat (20) @(posedge link_clk);
		chk("stops", 8'h02, 8'(i_i2r_bus_model.stops - s0));
		stop_test();
	end
endmodule

bind i2r_rx_core i2r_rx_checker i_i2r_rx_checker (.clock, .sys_rst,
	.link_clk, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
	.scl_out, .scl_oe, .sda_out, .sda_oe);
`default_nettype wire
